// ===== rtl/sacs_seq.sv
`timescale 1ns/1ns
module sacs_seq (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Register port
    input wire sacs_pkg::sacs_bus_s BUS,
    output logic [31:0] RDATA,
    // Start sources
    input wire sacs_pkg::sacs_trig_s TRIG,
    // Converter core
    input wire logic [11:0] SAMPLE,
    output logic POWER_ON,
    output logic TRACKING,
    output logic CONVERTING,
    output logic BIT_STROBE,
    output logic CLK_SRC_BURST,
    // Status
    output logic BUSY,
    output logic EOC
);
    import sacs_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        sacs_state_e st;
        logic enable;
        logic burst;
        logic [1:0] src;
        logic busy;
        logic eoc;
        logic [1:0] tmode;
        logic [3:0] tk;
        logic [4:0] div;
        logic [1:0] rpt;
        logic [4:0] pwr;
        logic [15:0] result;
        logic [15:0] acc;
        logic [4:0] done;
        logic [8:0] cnt;
        logic [4:0] dcnt;
        logic [3:0] bits;
        logic ext_prev;
        logic bit_stb;
        logic [31:0] rdata;
    } sacs_regs_s;

    sacs_regs_s r;
    sacs_regs_s next_r;

    logic start_evt;
    logic accepted;
    logic wr_ctrl;
    logic wr_cfg;
    logic [15:0] acc_sum;
    logic [4:0] done_inc;
    logic last_conv;
    logic [8:0] track_len;
    logic [31:0] ctrl_view;
    logic [31:0] cfg_view;

    // ------------------------------------------------------------
    // Start selection
    // ------------------------------------------------------------
    always_comb begin
        wr_ctrl = BUS.wr && (BUS.addr == SACS_OFF_CTRL);
        wr_cfg = BUS.wr && (BUS.addr == SACS_OFF_CFG);
        case (sacs_src_e'(r.src))
            SACS_SRC_SW: start_evt = wr_ctrl && BUS.wdata[SACS_CTRL_BUSY];
            SACS_SRC_PIN: start_evt = TRIG.ext_start && !r.ext_prev;
            SACS_SRC_T1: start_evt = TRIG.t1_ovf;
            SACS_SRC_T2: start_evt = TRIG.t2_16bit ? TRIG.t2_hi_ovf : TRIG.t2_lo_ovf;
            default: start_evt = 1'b0;
        endcase
        // A start only counts when idle and the converter may be used
        accepted = start_evt && (r.st == SACS_ST_IDLE) && (r.enable || r.burst);
        // Tracking length is the setting plus two subsystem cycles, counted down to zero
        track_len = {5'h00, r.tk} + SACS_TRACK_EXTRA - 9'h001;
        acc_sum = r.acc + {4'h0, SAMPLE};
        done_inc = r.done + 5'h01;
        last_conv = (done_inc == sacs_rpt_count(r.rpt));
        ctrl_view = 32'h0;
        ctrl_view[SACS_CTRL_ENABLE] = r.enable;
        ctrl_view[SACS_CTRL_BURST] = r.burst;
        ctrl_view[SACS_CTRL_SRC_LO +: 2] = r.src;
        ctrl_view[SACS_CTRL_BUSY] = r.busy;
        ctrl_view[SACS_CTRL_EOC] = r.eoc;
        cfg_view = 32'h0;
        cfg_view[SACS_CFG_TMODE_LO +: 2] = r.tmode;
        cfg_view[SACS_CFG_TK_LO +: 4] = r.tk;
        cfg_view[SACS_CFG_DIV_LO +: 5] = r.div;
        cfg_view[SACS_CFG_RPT_LO +: 2] = r.rpt;
        cfg_view[SACS_CFG_PWR_LO +: 5] = r.pwr;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.ext_prev = TRIG.ext_start;
        next_r.bit_stb = 1'b0;

        // Register writes; hardware set of the flag below overrides a clear
        if (wr_ctrl) begin
            next_r.enable = BUS.wdata[SACS_CTRL_ENABLE];
            next_r.burst = BUS.wdata[SACS_CTRL_BURST];
            next_r.src = BUS.wdata[SACS_CTRL_SRC_LO +: 2];
            if (!BUS.wdata[SACS_CTRL_EOC]) begin
                next_r.eoc = 1'b0;
            end
        end
        if (wr_cfg) begin
            next_r.tmode = BUS.wdata[SACS_CFG_TMODE_LO +: 2];
            next_r.tk = BUS.wdata[SACS_CFG_TK_LO +: 4];
            next_r.div = BUS.wdata[SACS_CFG_DIV_LO +: 5];
            next_r.rpt = BUS.wdata[SACS_CFG_RPT_LO +: 2];
            next_r.pwr = BUS.wdata[SACS_CFG_PWR_LO +: 5];
        end

        // Read data stands only in the cycle after the strobe
        next_r.rdata = 32'h0;
        if (BUS.rd) begin
            case (BUS.addr)
                SACS_OFF_CTRL: next_r.rdata = ctrl_view;
                SACS_OFF_CFG: next_r.rdata = cfg_view;
                SACS_OFF_RESULT: next_r.rdata = {16'h0000, r.result};
                default: next_r.rdata = 32'h0;
            endcase
        end

        case (r.st)
            SACS_ST_IDLE: begin
                if (accepted) begin
                    next_r.busy = 1'b1;
                    if (r.burst && !r.enable) begin
                        // Converter was shut down: wait for it to power up
                        next_r.st = SACS_ST_POWERUP;
                        next_r.cnt = 9'({4'h0, r.pwr} * SACS_PWR_UNIT) + SACS_PWR_UNIT - 9'h001;
                    end else if (!r.burst && (r.tmode == SACS_TM_PRE)) begin
                        next_r.st = SACS_ST_CSTART;
                    end else begin
                        // Pre-tracking under burst is not allowed; it runs as dual
                        next_r.st = SACS_ST_TRACK;
                        next_r.cnt = track_len;
                    end
                end
            end
            SACS_ST_POWERUP: begin
                if (r.cnt == 9'h000) begin
                    next_r.st = SACS_ST_TRACK;
                    next_r.cnt = track_len;
                end else begin
                    next_r.cnt = r.cnt - 9'h001;
                end
            end
            SACS_ST_TRACK: begin
                if (r.cnt == 9'h000) begin
                    next_r.st = SACS_ST_CSTART;
                end else begin
                    next_r.cnt = r.cnt - 9'h001;
                end
            end
            SACS_ST_CSTART: begin
                // One subsystem cycle to open the conversion
                next_r.st = SACS_ST_CBITS;
                next_r.bits = SACS_SAR_BITS - 4'h1;
                next_r.dcnt = r.div;
            end
            SACS_ST_CBITS: begin
                if (r.dcnt == 5'h00) begin
                    next_r.bit_stb = 1'b1;
                    next_r.dcnt = r.div;
                    if (r.bits == 4'h0) begin
                        next_r.st = SACS_ST_CEND;
                    end else begin
                        next_r.bits = r.bits - 4'h1;
                    end
                end else begin
                    next_r.dcnt = r.dcnt - 5'h01;
                end
            end
            SACS_ST_CEND: begin
                // One subsystem cycle to close the conversion and accumulate
                if (last_conv) begin
                    next_r.result = acc_sum;
                    next_r.acc = 16'h0000;
                    next_r.done = 5'h00;
                    next_r.eoc = 1'b1;
                    next_r.busy = 1'b0;
                    next_r.st = SACS_ST_IDLE;
                end else begin
                    next_r.acc = acc_sum;
                    next_r.done = done_inc;
                    if (r.burst) begin
                        next_r.st = SACS_ST_TRACK;
                        next_r.cnt = track_len;
                    end else begin
                        // Normal mode needs a fresh start for each conversion
                        next_r.busy = 1'b0;
                        next_r.st = SACS_ST_IDLE;
                    end
                end
            end
            default: begin
                next_r.st = SACS_ST_IDLE;
                next_r.busy = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            r <= '0;
            r.st <= SACS_ST_IDLE;
            r.src <= SACS_RST_SRC;
            r.tmode <= SACS_RST_TMODE;
            r.tk <= SACS_RST_TK;
            r.div <= SACS_RST_DIV;
            r.rpt <= SACS_RST_RPT;
            r.pwr <= SACS_RST_PWR;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_comb begin
        RDATA = r.rdata;
        // Powered whenever enabled, or while a burst sequence runs
        POWER_ON = r.enable || (r.burst && (r.st != SACS_ST_IDLE));
        CONVERTING = (r.st == SACS_ST_CSTART) || (r.st == SACS_ST_CBITS) || (r.st == SACS_ST_CEND);
        // Post-tracking leaves the capacitor disconnected while idle
        TRACKING = (r.st == SACS_ST_TRACK) ||
            ((r.st == SACS_ST_IDLE) && POWER_ON &&
             ((r.tmode == SACS_TM_PRE) || (r.tmode == SACS_TM_DUAL)));
        BIT_STROBE = r.bit_stb;
        CLK_SRC_BURST = r.burst;
        BUSY = r.busy;
        EOC = r.eoc;
    end

endmodule

// ===== rtl/sacs_pkg.sv
//------------------------------------------------------------
// Behaviour
// - Converter powered when enabled or bursting
// - Otherwise converter stays in low-power shutdown
// - Start from busy write, pin, timers
// - Busy during conversion; its fall after the last repeat sets flag
// - Result valid whenever end flag reads one
// - Timer 2 overflow byte follows timer width
// - Pre-tracking (normal mode only): convert at once, else track
// - Post-tracking: track, convert, then disconnect
// - Dual-tracking: track, convert, keep tracking
// - Subsystem clock source follows burst enable
// - Bit clock is divided subsystem clock
// - Tracking lasts setting plus two cycles
// - Conversion: 13 bit clocks plus two
// - Burst accumulates 1, 4, 8, 16 samples
// - Enable bit picks burst idle power state
// - Powered down: wait power-up, then track
// - Burst: one start, repeat-count conversions
// - End flag only after repeat-count conversions
// - Repeat count chosen by config field
// - Accumulated sum updated after last conversion
//------------------------------------------------------------
package sacs_pkg;

    // ------------------------------------------------------------
    // Register map (word index on the plain register port)
    // ------------------------------------------------------------
    localparam logic [3:0] SACS_OFF_CTRL = 4'h0;
    localparam logic [3:0] SACS_OFF_CFG = 4'h1;
    localparam logic [3:0] SACS_OFF_RESULT = 4'h2;

    // Control register fields
    localparam int SACS_CTRL_ENABLE = 0;
    localparam int SACS_CTRL_BURST = 1;
    localparam int SACS_CTRL_SRC_LO = 2;
    localparam int SACS_CTRL_BUSY = 4;
    localparam int SACS_CTRL_EOC = 5;

    // Config register fields
    localparam int SACS_CFG_TMODE_LO = 0;
    localparam int SACS_CFG_TK_LO = 2;
    localparam int SACS_CFG_DIV_LO = 6;
    localparam int SACS_CFG_RPT_LO = 11;
    localparam int SACS_CFG_PWR_LO = 13;

    // Reset values
    localparam logic [1:0] SACS_RST_SRC = 2'h0;
    localparam logic [1:0] SACS_RST_TMODE = 2'h1;
    localparam logic [3:0] SACS_RST_TK = 4'h0;
    localparam logic [4:0] SACS_RST_DIV = 5'h1F;
    localparam logic [1:0] SACS_RST_RPT = 2'h0;
    localparam logic [4:0] SACS_RST_PWR = 5'h1F;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam logic [8:0] SACS_TRACK_EXTRA = 9'h002;
    localparam logic [3:0] SACS_SAR_BITS = 4'hD;
    localparam logic [8:0] SACS_PWR_UNIT = 9'h008;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SACS_SRC_SW = 2'b00,
        SACS_SRC_PIN = 2'b01,
        SACS_SRC_T1 = 2'b10,
        SACS_SRC_T2 = 2'b11
    } sacs_src_e;

    typedef enum logic [1:0] {
        SACS_TM_RSVD = 2'b00,
        SACS_TM_POST = 2'b01,
        SACS_TM_PRE = 2'b10,
        SACS_TM_DUAL = 2'b11
    } sacs_tmode_e;

    typedef enum logic [2:0] {
        SACS_ST_IDLE = 3'b000,
        SACS_ST_POWERUP = 3'b001,
        SACS_ST_TRACK = 3'b010,
        SACS_ST_CSTART = 3'b011,
        SACS_ST_CBITS = 3'b100,
        SACS_ST_CEND = 3'b101
    } sacs_state_e;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } sacs_bus_s;

    typedef struct packed {
        logic ext_start;
        logic t1_ovf;
        logic t2_lo_ovf;
        logic t2_hi_ovf;
        logic t2_16bit;
    } sacs_trig_s;

    function automatic logic [4:0] sacs_rpt_count(input logic [1:0] code);
        case (code)
            2'h0: sacs_rpt_count = 5'h01;
            2'h1: sacs_rpt_count = 5'h04;
            2'h2: sacs_rpt_count = 5'h08;
            default: sacs_rpt_count = 5'h10;
        endcase
    endfunction

endpackage

// ===== verif/sacs_seq_chk.sv
`timescale 1ns/1ns
module sacs_seq_chk (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Watched ports
    input wire sacs_pkg::sacs_bus_s BUS,
    input wire logic POWER_ON,
    input wire logic TRACKING,
    input wire logic CONVERTING,
    input wire logic BIT_STROBE,
    input wire logic CLK_SRC_BURST,
    input wire logic BUSY,
    input wire logic EOC
);
    import sacs_pkg::*;
    // ------------------------------------------------------------
    // Mirrors of written controls and running counts
    // ------------------------------------------------------------
    logic en, burst;
    logic [1:0] tm;
    logic [3:0] tk;
    logic [3:0] nstb;
    logic [8:0] ntrk;
    always_ff @(posedge CLK) begin
        if (RST) begin
            en <= 1'b0;
            burst <= 1'b0;
            tm <= SACS_RST_TMODE;
            tk <= SACS_RST_TK;
        end else if (BUS.wr && BUS.addr == SACS_OFF_CTRL) begin
            en <= BUS.wdata[SACS_CTRL_ENABLE];
            burst <= BUS.wdata[SACS_CTRL_BURST];
        end else if (BUS.wr && BUS.addr == SACS_OFF_CFG) begin
            tm <= BUS.wdata[SACS_CFG_TMODE_LO +: 2];
            tk <= BUS.wdata[SACS_CFG_TK_LO +: 4];
        end
    end
    // Counts clear outside their phase, so stray strobes cannot pad a short count
    always_ff @(posedge CLK) begin
        nstb <= CONVERTING ? nstb + 4'(BIT_STROBE) : 4'h0;
        ntrk <= (TRACKING && BUSY) ? ntrk + 9'h001 : 9'h000;
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence conv_start;
        $rose(CONVERTING);
    endsequence
    sequence conv_end;
        $fell(CONVERTING);
    endsequence
    busy_power_a: assert property (BUSY || en |-> POWER_ON)
        else $error("converter unpowered while enabled or busy");
    idle_off_a: assert property (!en && !BUSY |-> !POWER_ON)
        else $error("converter powered while disabled and idle");
    bit_count_a: assert property (conv_end |-> nstb == 4'hD)
        else $error("wrong number of bit strobes in a conversion");
    track_len_a: assert property (conv_start ##0 tm != SACS_TM_PRE |->
        ntrk == {5'h00, tk} + SACS_TRACK_EXTRA) else $error("tracking length wrong");
    pre_start_a: assert property ($rose(BUSY) && tm == SACS_TM_PRE && !burst |-> CONVERTING)
        else $error("pre-tracking start did not convert at once");
    post_idle_a: assert property ($fell(BUSY) && tm == SACS_TM_POST |-> !TRACKING [*2])
        else $error("post-tracking kept tracking after conversion");
    dual_idle_a: assert property ($fell(BUSY) && tm == SACS_TM_DUAL && en |-> TRACKING)
        else $error("dual-tracking did not resume tracking");
    eoc_edge_a: assert property ($rose(EOC) |-> $fell(BUSY))
        else $error("end flag set without busy falling");
    conv_busy_a: assert property (CONVERTING |-> BUSY)
        else $error("converting while busy low");
    strobe_conv_a: assert property (BIT_STROBE |-> CONVERTING)
        else $error("bit strobe outside conversion");
    clk_src_a: assert property (CLK_SRC_BURST == burst)
        else $error("clock source select differs from burst bit");
    pwrup_wait_a: assert property ($rose(BUSY) && burst && !en |-> !TRACKING [*8])
        else $error("tracking began before power-up time");
endmodule
bind sacs_seq sacs_seq_chk i_sacs_seq_chk (.CLK, .RST, .BUS, .POWER_ON, .TRACKING,
    .CONVERTING, .BIT_STROBE, .CLK_SRC_BURST, .BUSY, .EOC);

// ===== verif/sacs_trig_model.sv
`timescale 1ns/1ns
module sacs_trig_model (
    // Clock
    input wire logic clk,
    // Requests: 1 pin, 2 timer 1, 3 timer 2 low byte, 4 timer 2 high byte
    input wire logic [2:0] kick,
    input wire logic t2_wide,
    // Start sources
    output sacs_pkg::sacs_trig_s trig
);
    import sacs_pkg::*;
    logic [1:0] pin_left = 2'h0;
    logic t1 = 1'b0;
    logic lo = 1'b0;
    logic hi = 1'b0;
    // Overflows are one-cycle pulses; the pin stays up three cycles like a slow edge
    always_ff @(posedge clk) begin
        t1 <= kick == 3'h2;
        lo <= kick == 3'h3;
        hi <= kick == 3'h4;
        pin_left <= (kick == 3'h1) ? 2'h3 : pin_left - 2'(pin_left != 2'h0);
    end
    // Requests never come closer than four cycles apart
    // The start pin is a dedicated input here, never shared with a port output
    assign trig = '{pin_left != 2'h0, t1, lo, hi, t2_wide};
endmodule

// ===== verif/sacs_seq_test.sv
`timescale 1ns/1ns
module sacs_seq_test;
    import sacs_pkg::*;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    sacs_bus_s bus = '0;
    sacs_trig_s trig;
    logic [31:0] rdata, v;
    logic [11:0] sample = 12'h5A3;
    logic [2:0] kick = 3'h0;
    logic t2w = 1'b0;
    logic pwr_on, trk, conv, bstb, csb, busy, eoc;
    int failures = 0;
    int n_tests = 0;
    int n, e;
    // tm, tk, div, burst, enable, power-up; pre-tracking only in normal mode
    int tc [6][6] = '{'{1, 0, 0, 0, 1, 0}, '{1, 3, 1, 0, 1, 0}, '{2, 0, 0, 0, 1, 0},
        '{3, 1, 0, 0, 1, 0}, '{1, 0, 0, 1, 1, 0}, '{3, 0, 0, 1, 0, 1}};
    logic [31:0] sums [4] = '{32'h0FFF, 32'h3FFC, 32'h7FF8, 32'hFFF0};
    always #10 CLK = ~CLK;
    sacs_seq i_sacs_seq (.CLK(CLK), .RST(RST), .BUS(bus), .RDATA(rdata), .TRIG(trig),
        .SAMPLE(sample), .POWER_ON(pwr_on), .TRACKING(trk), .CONVERTING(conv),
        .BIT_STROBE(bstb), .CLK_SRC_BURST(csb), .BUSY(busy), .EOC(eoc));
    sacs_trig_model i_sacs_trig_model (.clk(CLK), .kick(kick), .t2_wide(t2w), .trig(trig));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        if (failures == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge CLK);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge CLK);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge CLK);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic pulse(input logic [2:0] k);
        @(posedge CLK);
        kick <= k;
        @(posedge CLK);
        kick <= 3'h0;
    endtask
    // Waits for busy to drop or the end flag to rise; n counts cycles since the request
    task automatic wait_for(input bit on_busy);
        n = 1;
        #1;
        while ((on_busy ? busy !== 1'b0 : eoc !== 1'b1) && n < 3000) begin
            @(posedge CLK);
            #1;
            n++;
        end
    endtask
    function automatic logic [31:0] cfg(input int tm, tk, dv, rp, pw);
        return 32'(tm) | 32'(tk) << SACS_CFG_TK_LO | 32'(dv) << SACS_CFG_DIV_LO
            | 32'(rp) << SACS_CFG_RPT_LO | 32'(pw) << SACS_CFG_PWR_LO;
    endfunction
    function automatic logic [31:0] ctl(input int en, bu, sr, go);
        return 32'(en) | 32'(bu) << SACS_CTRL_BURST | 32'(sr) << SACS_CTRL_SRC_LO
            | 32'(go) << SACS_CTRL_BUSY;
    endfunction
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge CLK);
        failures++;
        end_sim();
    end
    initial begin
        repeat (10) @(posedge CLK);
        RST <= 1'b0;
        rd(SACS_OFF_CFG);
        check(v, cfg(1, 0, 31, 0, 31));
        rd(SACS_OFF_CTRL);
        check(v, 32'h0);
        rd(4'h7);
        check(v, 32'h0);
        wr(SACS_OFF_CTRL, ctl(0, 0, 0, 1));
        repeat (30) @(posedge CLK);
        check(busy, 32'h0);
        check(pwr_on, 32'h0);
        foreach (tc[i]) begin
            wr(SACS_OFF_CFG, cfg(tc[i][0], tc[i][1], tc[i][2], 0, tc[i][5]));
            // Mode bits go in first: a start is judged on the enable and burst already held
            wr(SACS_OFF_CTRL, ctl(tc[i][4], tc[i][3], 0, 0));
            wr(SACS_OFF_CTRL, ctl(tc[i][4], tc[i][3], 0, 1));
            wait_for(0);
            e = (tc[i][0] == 2 ? 0 : tc[i][1] + 2) + 16 + 13 * tc[i][2];
            e += (tc[i][3] && !tc[i][4]) ? (tc[i][5] + 1) * 8 : 0;
            check(n, e);
            rd(SACS_OFF_RESULT);
            check(v, {20'h0, sample});
            check(pwr_on, 32'(tc[i][4]));
        end
        for (int s = 1; s < 4; s++) begin
            wr(SACS_OFF_CTRL, ctl(1, 0, s, 0));
            pulse(3'(s));
            wait_for(0);
            check(eoc, 32'h1);
        end
        t2w <= 1'b1;
        wr(SACS_OFF_CTRL, ctl(1, 0, 3, 0));
        pulse(3'h3);
        repeat (30) @(posedge CLK);
        check(eoc, 32'h0);
        pulse(3'h4);
        wait_for(0);
        check(eoc, 32'h1);
        sample <= 12'hFFF;
        wr(SACS_OFF_CTRL, ctl(0, 1, 0, 0));
        for (int r = 0; r < 4; r++) begin
            wr(SACS_OFF_CFG, cfg(1, 0, 0, r, 0));
            wr(SACS_OFF_CTRL, ctl(0, 1, 0, 1));
            wait_for(0);
            rd(SACS_OFF_RESULT);
            check(v, sums[r]);
        end
        wr(SACS_OFF_CFG, cfg(1, 0, 0, 1, 0));
        wr(SACS_OFF_CTRL, ctl(1, 0, 0, 0));
        wr(SACS_OFF_CTRL, ctl(1, 0, 0, 1));
        wr(SACS_OFF_CTRL, ctl(1, 0, 0, 1));
        wait_for(1);
        check(n, 16);
        check(eoc, 32'h0);
        repeat (3) begin
            wr(SACS_OFF_CTRL, ctl(1, 0, 0, 1));
            wait_for(1);
        end
        check(eoc, 32'h1);
        rd(SACS_OFF_RESULT);
        check(v, 32'h3FFC);
        end_sim();
    end
endmodule
